// File: rtl/arith_bit_branch_exec.sv
// Execution datapath for add, shift, bit clear, bit test skip and relative branch
// Contract
// RULE1 - Add working register to file byte; update carry, digit carry, zero.
// RULE2 - Destination bit 0 writes working register, 1 writes file byte back.
// RULE3 - Add working register, carry and file byte; update carry, digit carry, zero.
// RULE4 - Arithmetic right shift keeps bit 7, old bit 0 to carry, sets carry and zero.
// RULE5 - Bit clear zeroes selected bit 0..7 of file byte; flags untouched.
// RULE6 - Skip-if-clear discards next instruction when bit is zero, two cycles.
// RULE7 - Branch target is branch address plus one plus signed 9-bit offset.
// RULE8 - Relative branch always takes two instruction cycles.
// RULE9 - PC change or true test costs two cycles, second is a no-operation.
// RULE10 - Digit carry is carry out of bit 3; zero set when result is zero.
// RULE11 - Carry set when add sum overflows bit 7, else cleared.
`timescale 1ns/100ps
module arith_bit_branch_exec
  import exec_pkg::*;
(
  // Clock and reset
  input  wire logic                clk,
  input  wire logic                sys_rst,
  // Decoded instruction
  input  wire logic                instr_valid,
  input  wire exec_op_t            instr_op,
  input  wire logic                instr_dest,
  input  wire logic [BITSEL_W-1:0] instr_bit,
  input  wire logic [OFS_W-1:0]    instr_offset,
  input  wire logic [PC_W-1:0]     instr_pc,
  // Addressed file byte read data
  input  wire logic [DATA_W-1:0]   file_rdata,
  // File byte write back
  output logic                     file_we,
  output logic [DATA_W-1:0]        file_wdata,
  // Working register and flags
  output logic [DATA_W-1:0]        wreg,
  output logic                     carry_flag,
  output logic                     digit_carry_flag,
  output logic                     zero_flag,
  // Program counter control
  output logic                     pc_load,
  output logic [PC_W-1:0]          pc_target,
  // Second-cycle no-operation marker
  output logic                     flush_cycle
);

  // Sequencer state and datapath intermediates
  exec_state_t         state;
  logic [DATA_W:0]     sum_full;
  logic [NIB_W:0]      nib_sum;
  logic [DATA_W-1:0]   result;
  logic                next_carry;
  // Decode qualifiers
  logic                writes_result;
  logic                sets_add_flags;
  logic                take_two;
  logic                accept;
  logic                branch_go;

  // Set one bit of a byte to zero
  // The mask follows the index, so any of the eight bits can be chosen
  function automatic logic [DATA_W-1:0] clear_bit(input logic [DATA_W-1:0] v,
                                                   input logic [BITSEL_W-1:0] b);
    logic [DATA_W-1:0] m;
    m = ~(8'h01 << b);
    return v & m;
  endfunction

  // True when the decoder presents a relative branch
  function automatic logic is_branch(input exec_op_t o);
    return o == OP_RELATIVE_BRANCH;
  endfunction

  // Instructions are ignored while the flush cycle runs, the decoder must hold off
  // No stall output: an instruction offered in the flush cycle is simply lost
  assign accept = instr_valid && (state == ST_EXEC);

  // One decode of the branch feeds both the strobe and the target register
  assign branch_go = accept && is_branch(instr_op);

  // Arithmetic results
  // Defaults keep the process free of latches and hold the carry
  always_comb begin
    sum_full       = '0;
    nib_sum        = '0;
    result         = ZERO_BYTE;
    next_carry     = carry_flag;
    writes_result  = 1'b0;
    sets_add_flags = 1'b0;
    take_two       = 1'b0;
    case (instr_op)
      OP_ADD_WREG_TO_FILE: begin
        // Plain sum; the nibble sum gives the carry out of bit 3
        sum_full       = {1'b0, wreg} + {1'b0, file_rdata}; // RULE1
        nib_sum        = {1'b0, wreg[NIB_W-1:0]} + {1'b0, file_rdata[NIB_W-1:0]};
        result         = sum_full[DATA_W-1:0];
        next_carry     = sum_full[DATA_W]; // RULE11
        writes_result  = 1'b1;
        sets_add_flags = 1'b1;
      end
      OP_ADD_WREG_FILE_CARRY: begin
        // RULE3
        // Carry in is the flag as it stands before this instruction
        sum_full       = {1'b0, wreg} + {1'b0, file_rdata} + {{DATA_W{1'b0}}, carry_flag};
        nib_sum        = {1'b0, wreg[NIB_W-1:0]} + {1'b0, file_rdata[NIB_W-1:0]}
                         + {{NIB_W{1'b0}}, carry_flag};
        result         = sum_full[DATA_W-1:0];
        next_carry     = sum_full[DATA_W]; // RULE11
        writes_result  = 1'b1;
        sets_add_flags = 1'b1;
      end
      OP_ARITH_SHIFT_RIGHT: begin
        // Bit 7 copied into itself keeps the sign
        result        = {file_rdata[MSB_POS], file_rdata[MSB_POS:1]}; // RULE4
        next_carry    = file_rdata[0]; // RULE4
        writes_result = 1'b1;
      end
      OP_CLEAR_FILE_BIT: begin
        // Written back whatever the destination bit says
        result = clear_bit(file_rdata, instr_bit); // RULE5
      end
      OP_TEST_BIT_SKIP_CLEAR: begin
        // A set bit lets the next instruction run in one cycle
        // Flags and data memory are not touched by the test
        take_two = ~file_rdata[instr_bit]; // RULE6
      end
      OP_RELATIVE_BRANCH: begin
        // Target is formed in the branch process below
        take_two = 1'b1; // RULE8
      end
      default: begin
        result = ZERO_BYTE;
      end
    endcase
  end

  // Two-cycle sequencer; second cycle runs as a no-operation
  // flush_cycle mirrors the flush state so the decoder sees the drop
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state       <= ST_EXEC;
      flush_cycle <= 1'b0;
    end else begin
      case (state)
        ST_EXEC: begin
          // Branch and taken skip claim the next cycle
          if (accept && take_two) begin
            state       <= ST_FLUSH; // RULE9
            flush_cycle <= 1'b1; // RULE9
          end else begin
            flush_cycle <= 1'b0;
          end
        end
        ST_FLUSH: begin
          // The instruction offered now is the discarded one
          state       <= ST_EXEC;
          flush_cycle <= 1'b0;
        end
        default: begin
          // Unreachable with a one-bit state, kept as a safe return
          state       <= ST_EXEC;
          flush_cycle <= 1'b0;
        end
      endcase
    end
  end

  // Working register destination
  // Only the adds and the shift may target the working register
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wreg <= ZERO_BYTE;
    end else if (accept && writes_result && instr_dest == DEST_WREG) begin
      wreg <= result; // RULE2
    end
  end

  // File write-back strobe; bit clear always writes the byte back
  // Data follows the datapath every cycle; only the strobe qualifies it
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      file_we    <= 1'b0;
      file_wdata <= ZERO_BYTE;
    end else begin
      file_we    <= accept && ((writes_result && instr_dest == DEST_FILE) // RULE2
                               || instr_op == OP_CLEAR_FILE_BIT); // RULE5
      file_wdata <= result;
    end
  end

  // Status flags; bit ops and branch leave them alone
  // The shift has no nibble carry, so digit carry keeps its value
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      carry_flag       <= 1'b0;
      digit_carry_flag <= 1'b0;
      zero_flag        <= 1'b0;
    end else if (accept && writes_result) begin
      // Zero follows the 8-bit result of each writing instruction
      carry_flag <= next_carry; // RULE4
      zero_flag  <= (result == ZERO_BYTE); // RULE10
      if (sets_add_flags) begin
        digit_carry_flag <= nib_sum[NIB_W]; // RULE10
      end
    end
  end

  // Branch target from incremented PC plus sign-extended offset
  // pc_target holds after the pulse so the fetch side may sample it late
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pc_load   <= 1'b0;
      pc_target <= PC_RESET;
    end else begin
      pc_load <= branch_go;
      if (branch_go) begin
        // Wraps modulo the PC width, like the fetch counter
        pc_target <= instr_pc + PC_STEP
                     + {{(PC_W-OFS_W){instr_offset[OFS_W-1]}}, instr_offset}; // RULE7
      end
    end
  end

endmodule

// File: rtl/exec_pkg.sv
// Constants and types shared by the arithmetic, bit and branch execution unit
package exec_pkg;
  localparam int DATA_W    = 8;
  localparam int PC_W      = 15;
  localparam int OFS_W     = 9;
  localparam int BITSEL_W  = 3;
  localparam int MSB_POS   = 7;
  localparam int NIB_W     = 4;
  localparam logic [DATA_W-1:0] ZERO_BYTE = 8'h00;
  localparam logic [PC_W-1:0]   PC_RESET  = 15'h0000;
  localparam logic [PC_W-1:0]   PC_STEP   = 15'h0001;

  // Operation codes presented by the decoder
  typedef enum logic [2:0] {
    OP_NOP                  = 3'b000,
    OP_ADD_WREG_TO_FILE     = 3'b001,
    OP_ADD_WREG_FILE_CARRY  = 3'b010,
    OP_ARITH_SHIFT_RIGHT    = 3'b011,
    OP_CLEAR_FILE_BIT       = 3'b100,
    OP_TEST_BIT_SKIP_CLEAR  = 3'b101,
    OP_RELATIVE_BRANCH      = 3'b110
  } exec_op_t;

  // Destination select values
  localparam logic DEST_WREG = 1'b0;
  localparam logic DEST_FILE = 1'b1;

  // Execution sequencer
  typedef enum logic [0:0] {
    ST_EXEC  = 1'b0,
    ST_FLUSH = 1'b1
  } exec_state_t;
endpackage

// File: verif/exec_asserts.sv
// Port assertions for the execution unit
`timescale 1ns/100ps
module exec_asserts
  import exec_pkg::*;
(
  // Inputs and outputs watched
  input wire logic                clk, sys_rst, instr_valid, instr_dest, file_we, pc_load,
  input wire logic                carry_flag, digit_carry_flag, zero_flag, flush_cycle,
  input wire exec_op_t            instr_op,
  input wire logic [BITSEL_W-1:0] instr_bit,
  input wire logic [OFS_W-1:0]    instr_offset,
  input wire logic [PC_W-1:0]     instr_pc, pc_target,
  input wire logic [DATA_W-1:0]   file_rdata, file_wdata, wreg
);
  logic              acc, add, cin, bitv;
  logic [8:0]        sum;
  logic [4:0]        nib;
  logic [7:0]        sh, clr;
  logic [PC_W-1:0]   tgt;
  // Expected results; the no-operation cycle accepts nothing
  assign acc  = instr_valid && !flush_cycle;
  assign add  = acc && (instr_op inside {OP_ADD_WREG_TO_FILE, OP_ADD_WREG_FILE_CARRY});
  assign cin  = (instr_op == OP_ADD_WREG_FILE_CARRY) && carry_flag;
  assign sum  = wreg + file_rdata + cin;
  assign nib  = wreg[3:0] + file_rdata[3:0] + cin;
  assign sh   = {file_rdata[7], file_rdata[7:1]};
  assign clr  = file_rdata & ~(8'h01 << instr_bit);
  assign bitv = file_rdata[instr_bit];
  assign tgt  = instr_pc + PC_STEP + {{6{instr_offset[8]}}, instr_offset};
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  a_add_to_wreg: assert property (
    add && !instr_dest |=> wreg == $past(sum[7:0]) && !file_we)
    else $error("add result missing from working register");
  a_add_to_file: assert property (
    add && instr_dest |=> file_we && file_wdata == $past(sum[7:0]) && $stable(wreg))
    else $error("add result missing from file write");
  a_add_flags: assert property (
    add |=> carry_flag == $past(sum[8]) && digit_carry_flag == $past(nib[4])
            && zero_flag == ($past(sum) == 9'h000 || $past(sum) == 9'h100))
    else $error("add flags wrong");
  a_shift_value: assert property (
    acc && instr_op == OP_ARITH_SHIFT_RIGHT
    |=> file_we == $past(instr_dest) && ($past(instr_dest) ? file_wdata : wreg) == $past(sh))
    else $error("shift result wrong");
  a_shift_flags: assert property (
    acc && instr_op == OP_ARITH_SHIFT_RIGHT
    |=> carry_flag == $past(file_rdata[0]) && zero_flag == ($past(sh) == 8'h00)
        && $stable(digit_carry_flag))
    else $error("shift flags wrong");
  a_clear_bit: assert property (
    acc && instr_op == OP_CLEAR_FILE_BIT
    |=> file_we && file_wdata == $past(clr)
        && $stable({carry_flag, digit_carry_flag, zero_flag}))
    else $error("bit clear wrong");
  a_skip_taken: assert property (
    acc && instr_op == OP_TEST_BIT_SKIP_CLEAR
    |=> flush_cycle == !$past(bitv) && !pc_load && !file_we)
    else $error("skip decision wrong");
  a_branch_tgt: assert property (
    acc && instr_op == OP_RELATIVE_BRANCH
    |=> pc_load && pc_target == $past(tgt) && flush_cycle ##1 !flush_cycle)
    else $error("branch target or length wrong");
  a_ctl_flags: assert property (
    acc && instr_op inside {OP_TEST_BIT_SKIP_CLEAR, OP_RELATIVE_BRANCH}
    |=> $stable({carry_flag, digit_carry_flag, zero_flag}) && $stable(wreg) && !file_we)
    else $error("test or branch changed state");
  a_flush_drop: assert property (
    flush_cycle |=> !file_we && !pc_load && !flush_cycle && $stable(wreg))
    else $error("no-operation cycle did work");
endmodule
bind arith_bit_branch_exec exec_asserts i_chk (.clk(clk), .sys_rst(sys_rst),
  .instr_valid(instr_valid), .instr_dest(instr_dest), .file_we(file_we), .pc_load(pc_load),
  .carry_flag(carry_flag), .digit_carry_flag(digit_carry_flag), .zero_flag(zero_flag),
  .flush_cycle(flush_cycle), .instr_op(instr_op), .instr_bit(instr_bit),
  .instr_offset(instr_offset), .instr_pc(instr_pc), .pc_target(pc_target),
  .file_rdata(file_rdata), .file_wdata(file_wdata), .wreg(wreg));

// File: verif/arith_bit_branch_exec_tb.sv
// Self-checking testbench for the execution unit
`timescale 1ns/100ps
module arith_bit_branch_exec_tb
  import exec_pkg::*;
;
  logic                clk = 1'b0, sys_rst = 1'b1, instr_valid = 1'b0, instr_dest = 1'b0;
  exec_op_t            instr_op = OP_NOP;
  logic [BITSEL_W-1:0] instr_bit = 3'h0;
  logic [OFS_W-1:0]    instr_offset = 9'h000;
  logic [PC_W-1:0]     instr_pc = 15'h0000, pc_target;
  logic [DATA_W-1:0]   file_rdata = 8'h00, file_wdata, wreg;
  logic                file_we, carry_flag, digit_carry_flag, zero_flag, pc_load, flush_cycle;
  int                  n_fail = 0, n_compared = 0;
  // 50 MHz clock
  always #10 clk = ~clk;
  arith_bit_branch_exec i_dut (.clk(clk), .sys_rst(sys_rst), .instr_valid(instr_valid),
    .instr_op(instr_op), .instr_dest(instr_dest), .instr_bit(instr_bit),
    .instr_offset(instr_offset), .instr_pc(instr_pc), .file_rdata(file_rdata),
    .file_we(file_we), .file_wdata(file_wdata), .wreg(wreg), .carry_flag(carry_flag),
    .digit_carry_flag(digit_carry_flag), .zero_flag(zero_flag), .pc_load(pc_load),
    .pc_target(pc_target), .flush_cycle(flush_cycle));
  task automatic chk(string name, logic [15:0] exp, logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask
  // Flags as {carry, digit carry, zero}
  task automatic fl(logic [2:0] e);
    chk("flags", e, {carry_flag, digit_carry_flag, zero_flag});
  endtask
  // One instruction, presented 1 ns after an edge; valid held until the next call
  task automatic op(exec_op_t o, logic d, logic [2:0] b, logic [8:0] k, logic [14:0] p,
                    logic [7:0] f);
    instr_valid = 1'b1;
    instr_op = o;
    instr_dest = d;
    instr_bit = b;
    instr_offset = k;
    instr_pc = p;
    file_rdata = f;
    @(posedge clk);
    #1;
  endtask
  task automatic t_add;
    op(OP_ADD_WREG_TO_FILE, 1'b0, 3'h0, 9'h000, 15'h0000, 8'h08);
    chk("wreg", 8'h08, wreg);
    op(OP_ADD_WREG_TO_FILE, 1'b1, 3'h0, 9'h000, 15'h0000, 8'hf8);
    chk("wdata", 8'h00, file_wdata);
    chk("wreg", 8'h08, wreg);
    chk("we", 1'b1, file_we);
    fl(3'h7);
    op(OP_ADD_WREG_FILE_CARRY, 1'b0, 3'h0, 9'h000, 15'h0000, 8'h08);
    chk("wreg", 8'h11, wreg);
    fl(3'h2);
  endtask
  task automatic t_shift;
    op(OP_ARITH_SHIFT_RIGHT, 1'b0, 3'h0, 9'h000, 15'h0000, 8'h81);
    chk("wreg", 8'hc0, wreg);
    fl(3'h6);
    op(OP_ARITH_SHIFT_RIGHT, 1'b1, 3'h0, 9'h000, 15'h0000, 8'h01);
    chk("wdata", 8'h00, file_wdata);
    fl(3'h7);
  endtask
  // Every bit position, flags must not move
  task automatic t_clear;
    for (int b = 0; b < 8; b++) begin
      op(OP_CLEAR_FILE_BIT, 1'b0, 3'(b), 9'h000, 15'h0000, 8'hff);
      chk("wdata", 8'hff ^ (8'h01 << b), file_wdata);
      fl(3'h7);
    end
  endtask
  // Skip not taken, then taken with the next instruction dropped
  task automatic t_skip;
    op(OP_TEST_BIT_SKIP_CLEAR, 1'b0, 3'h3, 9'h000, 15'h0000, 8'h08);
    chk("flush", 1'b0, flush_cycle);
    op(OP_TEST_BIT_SKIP_CLEAR, 1'b0, 3'h3, 9'h000, 15'h0000, 8'hf7);
    chk("flush", 1'b1, flush_cycle);
    fl(3'h7);
    op(OP_ADD_WREG_TO_FILE, 1'b1, 3'h0, 9'h000, 15'h0000, 8'h55);
    chk("we", 1'b0, file_we);
    op(OP_ADD_WREG_TO_FILE, 1'b0, 3'h0, 9'h000, 15'h0000, 8'h40);
    chk("wreg", 8'h00, wreg);
    fl(3'h5);
  endtask
  // Offset extremes and wrap; a branch in the no-operation cycle is dropped
  task automatic t_branch;
    logic [14:0] pcs[3] = '{15'h0010, 15'h0100, 15'h7fff};
    logic [8:0]  ofs[3] = '{9'h1ff, 9'h100, 9'h0ff};
    logic [14:0] tgt[3] = '{15'h0010, 15'h0001, 15'h00ff};
    for (int i = 0; i < 3; i++) begin
      op(OP_RELATIVE_BRANCH, 1'b0, 3'h0, ofs[i], pcs[i], 8'h00);
      chk("target", tgt[i], pc_target);
      chk("flush", 1'b1, flush_cycle);
      chk("load", 1'b1, pc_load);
      op(OP_RELATIVE_BRANCH, 1'b0, 3'h0, 9'h000, 15'h0200, 8'h00);
      chk("load", 1'b0, pc_load);
      chk("target", tgt[i], pc_target);
      chk("flush", 1'b0, flush_cycle);
      fl(3'h5);
    end
  endtask
  task automatic print_verdict;
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // Main sequence after a 6-cycle reset
  initial begin
    repeat (6) @(posedge clk);
    #1;
    sys_rst = 1'b0;
    t_add();
    t_shift();
    t_clear();
    t_skip();
    t_branch();
    instr_valid = 1'b0;
    print_verdict();
  end
  // Watchdog, far beyond the 29 cycles the reset and tests need
  initial begin
    #20000;
    n_fail++;
    print_verdict();
  end
endmodule
